// >>> hdl/rcs_pkg.sv
// package for the reset configuration sampler
package rcs_pkg;
  localparam int unsigned CFG_W           = 16;
  localparam int unsigned AD_W            = 32;
  // pins with gated pull-up; ratio pins (low byte) have none
  localparam logic [15:0] PULLUP_MASK     = 16'hFF00;
  localparam logic [15:0] CFG_RST         = 16'hFFFF;
  localparam int unsigned ARB_EN_BIT      = 8;
  // pull-up hold after release, in platform clocks
  localparam int unsigned HOLD_CLKS       = 4;
  localparam logic [2:0]  HOLD_CNT        = 3'(HOLD_CLKS);
  // tap reset needs five tck edges with tms high
  localparam logic [2:0]  TAP_RST_CNT     = 3'h5;
  // register map (byte addresses)
  localparam logic [7:0]  OFS_CFG         = 8'h00;
  localparam logic [7:0]  OFS_DEVDIS      = 8'h04;
  localparam logic [7:0]  OFS_STATUS      = 8'h08;
  localparam int unsigned DEVDIS_PCI_BIT  = 0;
  localparam logic [31:0] DEVDIS_RST      = 32'h0000_0000;
  localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;
  localparam logic [AD_W-1:0] AD_PARK     = 32'h0000_0000;

  typedef enum logic [1:0] {
    RCS_RESET   = 2'b00,
    RCS_HOLD    = 2'b01,
    RCS_RUN     = 2'b10
  } rcs_state_t;

  typedef struct packed {
    logic [CFG_W-1:0] value;
    logic             valid;
  } rcs_cfg_t;
endpackage

// >>> hdl/rcs_sampler.sv
// reset configuration sampler with debug reset duties and ahb-lite registers
// Function
// RULE1: while hard reset is low, config pins are inputs, drivers off.
// RULE2: latch config levels at hard reset release, then pins return to outputs.
// RULE3: gated pull-ups on during hard reset plus few clocks, off with receiver.
// RULE4: gated pull-up bits read high as default setting.
// RULE5: board drives every ratio pin; those have no internal pull-up.
// RULE6: system holds test reset asserted during reset.
// RULE7: tap reaches reset state by tck and tms alone.
// RULE8: probe asserts hard reset and test reset independently.
// RULE9: board merges probe reset requests with other reset sources.
// RULE10: soft reset assertion raises machine check to core.
// RULE11: arbiter strapped on: drive all pci ad pins stable after reset.
// RULE12: arbiter strapped off: leave pci ad pins as inputs.
// RULE13: software may disable pci block via device disable register.
// RULE14: latched config stays constant until next hard reset.
`timescale 1ns/1ps
`default_nettype none
module rcs_sampler
  import rcs_pkg::*;
(
  input  wire logic                      hclk,
  input  wire logic                      hresetn,
  input  wire logic                      hard_reset_n,
  input  wire logic                      soft_reset_n,
  input  wire logic                      test_reset_n,
  input  wire logic                      tck_sample,
  input  wire logic                      tms,
  input  wire logic [rcs_pkg::CFG_W-1:0] cfg_pin_in,
  output logic      [rcs_pkg::CFG_W-1:0] cfg_pin_oe,
  output logic      [rcs_pkg::CFG_W-1:0] cfg_pullup_en,
  output logic      [rcs_pkg::CFG_W-1:0] cfg_rcv_en,
  output logic      [rcs_pkg::AD_W-1:0]  pci_ad_out,
  output logic                           pci_ad_oe,
  output logic                           pci_disable,
  output logic                           machine_check,
  output logic                           tap_in_reset,
  output rcs_pkg::rcs_cfg_t              cfg_latched,
  input  wire logic                      hsel,
  input  wire logic [31:0]               haddr,
  input  wire logic [1:0]                htrans,
  input  wire logic                      hwrite,
  input  wire logic [2:0]                hsize,
  input  wire logic [31:0]               hwdata,
  input  wire logic                      hready,
  output logic      [31:0]               hrdata,
  output logic                           hreadyout,
  output logic                           hresp
);
  import rcs_pkg::*;

  function automatic logic [7:0] word_ofs(input logic [31:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction

  rcs_state_t        state;
  rcs_state_t        next_state;
  logic [2:0]        hold_cnt;
  logic [2:0]        next_hold_cnt;
  rcs_cfg_t          next_cfg;
  logic              srst_d;
  logic              next_srst_d;
  logic              next_mc;
  logic              tck_d;
  logic              next_tck_d;
  logic [2:0]        tms_cnt;
  logic [2:0]        next_tms_cnt;
  logic              next_tap_rst;
  logic [31:0]       devdis;
  logic [31:0]       next_devdis;
  logic              wr_pend;
  logic              next_wr_pend;
  logic [7:0]        wr_ofs;
  logic [7:0]        next_wr_ofs;
  logic [31:0]       next_hrdata;
  logic              arb_en;
  logic              run;
  logic              tck_rise;
  logic              take;

  assign arb_en   = cfg_latched.value[ARB_EN_BIT];
  assign run      = (state == RCS_RUN);
  assign tck_rise = tck_sample & ~tck_d;
  assign take     = hsel & hready & (htrans == HTRANS_NONSEQ);

  // capture sequencer and config latch
  always_comb begin
    next_state    = state;
    next_hold_cnt = hold_cnt;
    next_cfg      = cfg_latched;
    case (state)
      RCS_RESET: begin
        next_cfg.valid = 1'b0;
        if (hard_reset_n) begin
          next_cfg.value = cfg_pin_in; // RULE2
          next_cfg.valid = 1'b1;
          next_hold_cnt  = HOLD_CNT;
          next_state     = RCS_HOLD;
        end
      end
      RCS_HOLD: begin
        // pull-up kept a few clocks so the edge is clean; value already frozen
        if (hold_cnt == 3'h1) begin
          next_state = RCS_RUN;
        end
        next_hold_cnt = hold_cnt - 3'h1;
      end
      RCS_RUN: begin
        next_state = RCS_RUN; // RULE14
      end
      default: begin
        next_state = RCS_RESET;
      end
    endcase
    if (!hard_reset_n) begin
      next_state     = RCS_RESET;
      next_cfg.valid = 1'b0;
    end
  end

  // pin control, registered so outputs stay glitch free
  logic [CFG_W-1:0] next_oe;
  logic [CFG_W-1:0] next_pu;
  logic [CFG_W-1:0] next_rcv;
  logic             next_ad_oe;
  always_comb begin
    next_oe    = '0;
    next_pu    = '0;
    next_rcv   = '0;
    next_ad_oe = 1'b0;
    if (next_state == RCS_RESET) begin
      next_rcv = '1; // RULE1
      next_pu  = PULLUP_MASK; // RULE3 RULE4
    end else if (next_state == RCS_HOLD) begin
      next_rcv = '1;
      next_pu  = PULLUP_MASK; // RULE3
    end else begin
      next_oe = '1; // RULE2
      // arbiter parks the bus unless software shut the pci block off
      next_ad_oe = next_cfg.value[ARB_EN_BIT] & ~next_devdis[DEVDIS_PCI_BIT]; // RULE11 RULE12
    end
  end

  // soft reset edge raises machine check; tap reset via tms
  always_comb begin
    next_srst_d  = soft_reset_n;
    next_mc      = srst_d & ~soft_reset_n; // RULE10
    next_tck_d   = tck_sample;
    next_tms_cnt = tms_cnt;
    next_tap_rst = tap_in_reset;
    if (!test_reset_n) begin
      next_tms_cnt = '0;
      next_tap_rst = 1'b1;
    end else if (tck_rise) begin
      if (!tms) begin
        next_tms_cnt = '0;
        next_tap_rst = 1'b0;
      end else if (tms_cnt == TAP_RST_CNT - 3'h1) begin
        next_tap_rst = 1'b1; // RULE7
      end else begin
        next_tms_cnt = tms_cnt + 3'h1;
      end
    end
  end

  // ahb-lite slave, zero wait states
  always_comb begin
    next_wr_pend = take & hwrite;
    next_wr_ofs  = word_ofs(haddr);
    next_devdis  = devdis;
    next_hrdata  = hrdata;
    if (wr_pend && wr_ofs == OFS_DEVDIS && run) begin
      next_devdis = hwdata; // RULE13
    end
    if (take && !hwrite) begin
      if (word_ofs(haddr) == OFS_CFG) begin
        next_hrdata = {15'h0000, cfg_latched.valid, cfg_latched.value};
      end else if (word_ofs(haddr) == OFS_DEVDIS) begin
        next_hrdata = devdis;
      end else if (word_ofs(haddr) == OFS_STATUS) begin
        next_hrdata = {26'h0000000, arb_en, pci_ad_oe, tap_in_reset, ~soft_reset_n, state};
      end else begin
        next_hrdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state         <= RCS_RESET;
      hold_cnt      <= 3'h0;
      cfg_latched   <= '{value: CFG_RST, valid: 1'b0};
      cfg_pin_oe    <= '0;
      cfg_pullup_en <= PULLUP_MASK;
      cfg_rcv_en    <= '1;
      pci_ad_oe     <= 1'b0;
      pci_ad_out    <= AD_PARK;
      pci_disable   <= 1'b0;
      srst_d        <= 1'b1;
      machine_check <= 1'b0;
      tck_d         <= 1'b0;
      tms_cnt       <= 3'h0;
      tap_in_reset  <= 1'b1;
      devdis        <= DEVDIS_RST;
      wr_pend       <= 1'b0;
      wr_ofs        <= 8'h00;
      hrdata        <= 32'h0000_0000;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end else begin
      state         <= next_state;
      hold_cnt      <= next_hold_cnt;
      cfg_latched   <= next_cfg;
      cfg_pin_oe    <= next_oe;
      cfg_pullup_en <= next_pu;
      cfg_rcv_en    <= next_rcv;
      pci_ad_oe     <= next_ad_oe;
      pci_ad_out    <= AD_PARK;
      pci_disable   <= next_devdis[DEVDIS_PCI_BIT];
      srst_d        <= next_srst_d;
      machine_check <= next_mc;
      tck_d         <= next_tck_d;
      tms_cnt       <= next_tms_cnt;
      tap_in_reset  <= next_tap_rst;
      devdis        <= next_devdis;
      wr_pend       <= next_wr_pend;
      wr_ofs        <= next_wr_ofs;
      hrdata        <= next_hrdata;
      hreadyout     <= 1'b1;
      hresp         <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// >>> test/rcs_monitor.sv
// assertions on the sampler ports
`timescale 1ns/1ps
`default_nettype none
module rcs_monitor
  import rcs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hard_reset_n,
  input wire logic        soft_reset_n,
  input wire logic        test_reset_n,
  input wire logic        tck_sample,
  input wire logic        tms,
  input wire logic [15:0] cfg_pin_oe,
  input wire logic [15:0] cfg_pullup_en,
  input wire logic [15:0] cfg_rcv_en,
  input wire logic [31:0] pci_ad_out,
  input wire logic        pci_ad_oe,
  input wire logic        pci_disable,
  input wire logic        machine_check,
  input wire logic        tap_in_reset,
  input wire rcs_cfg_t    cfg_latched
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  a_pins_input: assert property (!hard_reset_n [*2] |=> cfg_pin_oe == 16'h0
    && cfg_rcv_en == 16'hFFFF && cfg_pullup_en == PULLUP_MASK) else $error("pins not inputs");
  a_pullup_hold: assert property ($rose(cfg_latched.valid) |->
    cfg_pullup_en == PULLUP_MASK ##[1:8] cfg_pullup_en == 16'h0) else $error("pull-up hold");
  a_rcv_off: assert property (cfg_rcv_en == 16'h0 |-> cfg_pullup_en == 16'h0
    && cfg_pin_oe == 16'hFFFF) else $error("receiver and pull-up apart");
  a_latch_clear: assert property (!hard_reset_n [*2] |=> !cfg_latched.valid)
    else $error("valid kept in hard reset");
  a_latch_stable: assert property (cfg_latched.valid && $past(cfg_latched.valid)
    |-> $stable(cfg_latched.value)) else $error("latched value moved");
  a_ad_drive: assert property (pci_ad_oe |-> cfg_latched.value[ARB_EN_BIT]
    && pci_ad_out == AD_PARK && $stable(pci_ad_out)) else $error("ad driven wrongly");
  a_ad_disable: assert property (pci_disable [*2] |-> !pci_ad_oe)
    else $error("ad driven while disabled");
  a_mcheck_pulse: assert property ($fell(soft_reset_n) |->
    ##[1:3] machine_check ##1 !machine_check) else $error("no machine check pulse");
  // test reset held low keeps the tap in reset, so a tms-low rise only counts when released
  a_tap_leave: assert property ($rose(tck_sample) && !tms && test_reset_n |->
    ##[1:3] !tap_in_reset) else $error("tap stuck in reset");
endmodule
bind rcs_sampler rcs_monitor u_mon (.hclk, .hresetn, .hard_reset_n, .soft_reset_n, .test_reset_n,
  .tck_sample, .tms, .cfg_pin_oe, .cfg_pullup_en, .cfg_rcv_en, .pci_ad_out, .pci_ad_oe,
  .pci_disable, .machine_check, .tap_in_reset, .cfg_latched);
`default_nettype wire

// >>> test/rcs_board.sv
// board straps and debug probe around the sampler
`timescale 1ns/1ps
`default_nettype none
module rcs_board
  import rcs_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic [15:0] strap,
  input  wire logic        probe_hard_reset_n_n,
  input  wire logic        probe_trst_n,
  input  wire logic        other_rst_n,
  input  wire logic [15:0] cfg_pin_oe,
  input  wire logic [15:0] cfg_pullup_en,
  output logic      [15:0] cfg_pin_in,
  output logic             hard_reset_n,
  output logic             test_reset_n
);
  logic [15:0] tog = 16'hA5C3;
  always_ff @(posedge hclk) tog <= ~tog;
  // undriven pins read the strap, except gated pull-up pins with pull-up off, which toggle where strapped high
  assign cfg_pin_in = (cfg_pin_oe & tog)
    | (~cfg_pin_oe & strap & (~PULLUP_MASK | cfg_pullup_en | tog));
  assign hard_reset_n = probe_hard_reset_n_n & other_rst_n;
  assign test_reset_n = probe_trst_n & other_rst_n;
endmodule
`default_nettype wire

// >>> test/testbench.sv
// testbench for the reset configuration sampler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import rcs_pkg::*;
  logic        hclk = 1'h0, hresetn = 1'h0, soft_reset_n = 1'h1, tck_sample = 1'h0, tms = 1'h1;
  logic        probe_hard_reset_n_n = 1'h0, probe_trst_n = 1'h0, other_rst_n = 1'h1, hsel = 1'h0;
  logic        hwrite = 1'h0, hard_reset_n, test_reset_n, hreadyout, hresp;
  logic        pci_ad_oe, pci_disable, machine_check, tap_in_reset;
  logic [15:0] strap = 16'hFE5A, cfg_pin_in, cfg_pin_oe, cfg_pullup_en, cfg_rcv_en;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, pci_ad_out, r;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  rcs_cfg_t    cfg_latched;
  int          miscompares = 0, checked = 0, n;
  rcs_board u_board (.hclk, .strap, .probe_hard_reset_n_n, .probe_trst_n, .other_rst_n, .cfg_pin_oe,
    .cfg_pullup_en, .cfg_pin_in, .hard_reset_n, .test_reset_n);
  rcs_sampler u_dut (.hclk, .hresetn, .hard_reset_n, .soft_reset_n, .test_reset_n, .tck_sample,
    .tms, .cfg_pin_in, .cfg_pin_oe, .cfg_pullup_en, .cfg_rcv_en, .pci_ad_out, .pci_ad_oe,
    .pci_disable, .machine_check, .tap_in_reset, .cfg_latched, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp);
  initial forever #2.5 hclk = ~hclk;
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single transfer; hready is polled, the watchdog bounds a hang
  task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'h1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'h1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic tck_rise;
    tck_sample <= 1'h1;
    cyc(3);
    tck_sample <= 1'h0;
    cyc(3);
  endtask
  task automatic tally_and_finish;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    cyc(5);
    hresetn <= 1'h1;
    cyc(3);
    chk(32'(cfg_pin_oe), 32'h0);
    chk(32'(cfg_pullup_en), 32'hFF00);
    probe_hard_reset_n_n <= 1'h1;
    probe_trst_n <= 1'h1;
    cyc(12);
    chk(32'({cfg_latched.valid, cfg_latched.value}), 32'h1FE5A);
    chk({cfg_pin_oe, cfg_rcv_en | cfg_pullup_en}, 32'hFFFF0000);
    chk(32'(pci_ad_oe), 32'h0);
    ahb(OFS_CFG, 1'h1, 32'h0);
    ahb(OFS_CFG, 1'h0, 32'h0);
    chk(r, 32'h1FE5A);
    chk(32'({hresp, hreadyout}), 32'h1);
    strap <= 16'hFF3C;
    other_rst_n <= 1'h0;
    // device disable write during hard reset must be dropped
    ahb(OFS_DEVDIS, 1'h1, 32'h1);
    cyc(2);
    other_rst_n <= 1'h1;
    cyc(12);
    chk(32'({cfg_latched.valid, cfg_latched.value}), 32'h1FF3C);
    chk({pci_ad_out[30:0], pci_ad_oe}, 32'h1);
    ahb(OFS_DEVDIS, 1'h0, 32'h0);
    chk(r, 32'h0);
    ahb(OFS_DEVDIS, 1'h1, 32'h1);
    ahb(OFS_DEVDIS, 1'h0, 32'h0);
    chk(r, 32'h1);
    cyc(3);
    chk({pci_disable, pci_ad_oe}, 32'h2);
    ahb(OFS_DEVDIS, 1'h1, 32'h0);
    ahb(8'h10, 1'h0, 32'h0);
    chk(r, 32'h0);
    ahb(OFS_STATUS, 1'h0, 32'h0);
    chk(32'(r[5:4]), 32'h3);
    soft_reset_n <= 1'h0;
    n = 0;
    repeat (6) begin
      @(posedge hclk);
      if (machine_check === 1'h1) n++;
    end
    chk(32'(n), 32'h1);
    soft_reset_n <= 1'h1;
    tms <= 1'h0;
    tck_rise();
    chk(32'(tap_in_reset), 32'h0);
    tms <= 1'h1;
    repeat (4) tck_rise();
    chk(32'(tap_in_reset), 32'h0);
    tck_rise();
    chk(32'(tap_in_reset), 32'h1);
    tally_and_finish();
  end
  initial begin
    #20000;
    miscompares++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
